// >>> verilog/afp_top.sv
// Framework side of the accelerator port: AXI4-Lite registers, run and step
// control of the gated accelerator clock, parameter words, probe readback and
// the bank-0 read port. Assumes the accelerator runs on a clock gated from
// i_clk by o_acc_clk_en, so its outputs are already in this clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "afp_defs.svh"

module afp_top #(
	parameter int PROBE_COUNT = `AFP_PROBE_MAX
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [11:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_acc_clk_en,
	output logic o_acc_reset,
	input wire logic i_step_flag,
	input wire logic i_job_finished,
	input wire logic [`AFP_ADDR_W-1:0] i_bank0_read_address,
	input wire logic i_bank0_read_request,
	output logic [`AFP_DATA_W-1:0] o_bank0_read_word,
	output logic o_bank0_read_valid,
	input wire logic [`AFP_PROBE_MAX*`AFP_WORD_W-1:0] i_probe_output_n,
	output logic [`AFP_PARAM_COUNT*`AFP_WORD_W-1:0] o_param_value,
	input wire logic [`AFP_PARAM_COUNT*`AFP_WORD_W-1:0] i_param_reset_value,
	input wire logic i_param_reset_select,
	output logic [`AFP_ADDR_W-1:0] o_sram0_rd_addr,
	output logic o_sram0_rd_req,
	input wire logic [`AFP_DATA_W-1:0] i_sram0_rd_data,
	input wire logic i_sram0_rd_valid,
	output logic o_sram0_acc_grant
);
	localparam int PW = `AFP_WORD_W;

	// Probe indices decode from six address bits, so more than 64 probes
	// cannot be reached and zero probes leaves nothing to read
	if (PROBE_COUNT < 1 || PROBE_COUNT > `AFP_PROBE_MAX) begin : g_bad_probe_count
		$error("PROBE_COUNT must lie in 1..64");
	end

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_param(input logic [11:0] a);
		return a[11:8] == `AFP_PARAM_BASE && a[7:6] == 2'h0;
	endfunction

	function automatic logic is_probe(input logic [11:0] a);
		return a[11:9] == `AFP_PROBE_BASE;
	endfunction

	// Run control state
	afp_pkg::afp_run_state_e state, next_state;
	logic [2:0] rst_cnt, next_rst_cnt;
	logic [`AFP_STEP_W-1:0] steps_left, next_steps_left;
	logic [31:0] steps_done, next_steps_done;
	logic debug_mode, next_debug_mode;
	logic run_done, next_run_done;
	logic next_acc_clk_en, next_acc_reset, next_grant;

	// Bus state
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [`AFP_PARAM_COUNT*PW-1:0] next_param;

	// Decoded write strobes to the run control
	logic wr_commit, start_req, step_req;
	logic [31:0] ctrl_val;
	logic [63:0] probe_word;

	always_comb begin
		wr_commit = aw_held & w_held & ~o_s_axi_bvalid;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = o_s_axi_bvalid;
		next_bresp = o_s_axi_bresp;
		next_param = o_param_value;
		start_req = 1'b0;
		step_req = 1'b0;
		ctrl_val = merge_strb(`AFP_ZERO32, w_data, w_strb);
		if (o_s_axi_awready && i_s_axi_awvalid) begin
			next_aw_held = 1'b1;
			next_aw_addr = i_s_axi_awaddr;
		end
		if (o_s_axi_wready && i_s_axi_wvalid) begin
			next_w_held = 1'b1;
			next_w_data = i_s_axi_wdata;
			next_w_strb = i_s_axi_wstrb;
		end
		if (o_s_axi_bvalid && i_s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_commit) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `AFP_RESP_OKAY;
			if (is_param(aw_addr)) begin
				next_param[aw_addr[5:3]*PW + aw_addr[2]*32 +: 32] =
					merge_strb(o_param_value[aw_addr[5:3]*PW + aw_addr[2]*32 +: 32], w_data, w_strb);
			end else if (aw_addr == `AFP_CTRL_OFS) begin
				start_req = ctrl_val[`AFP_CTRL_START_BIT];
			end else if (aw_addr == `AFP_STEP_OFS) begin
				step_req = 1'b1;
			end else if (aw_addr != `AFP_STATUS_OFS && aw_addr != `AFP_STEPS_DONE_OFS) begin
				next_bresp = `AFP_RESP_SLVERR;
			end
		end
		next_awready = ~next_aw_held & ~next_bvalid;
		next_wready = ~next_w_held & ~next_bvalid;
	end

	always_comb begin
		next_arready = o_s_axi_arready;
		next_rvalid = o_s_axi_rvalid;
		next_rdata = o_s_axi_rdata;
		next_rresp = o_s_axi_rresp;
		probe_word = '0;
		if (i_s_axi_araddr[8:3] < PROBE_COUNT) begin
			probe_word = i_probe_output_n[i_s_axi_araddr[8:3]*PW +: PW];
		end
		if (o_s_axi_rvalid && i_s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (o_s_axi_arready && i_s_axi_arvalid) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `AFP_RESP_OKAY;
			next_rdata = `AFP_ZERO32;
			if (is_param(i_s_axi_araddr)) begin
				next_rdata = o_param_value[i_s_axi_araddr[5:3]*PW + i_s_axi_araddr[2]*32 +: 32];
			end else if (is_probe(i_s_axi_araddr)) begin
				next_rdata = i_s_axi_araddr[2] ? probe_word[63:32] : probe_word[31:0];
			end else if (i_s_axi_araddr == `AFP_CTRL_OFS) begin
				next_rdata[`AFP_CTRL_DEBUG_BIT] = debug_mode;
			end else if (i_s_axi_araddr == `AFP_STATUS_OFS) begin
				next_rdata[`AFP_STAT_BUSY_BIT] = state != afp_pkg::afp_st_idle &&
					state != afp_pkg::afp_st_stopped;
				next_rdata[`AFP_STAT_DONE_BIT] = run_done;
				next_rdata[`AFP_STAT_RESET_BIT] = o_acc_reset;
				next_rdata[`AFP_STAT_DEBUG_BIT] = debug_mode;
			end else if (i_s_axi_araddr == `AFP_STEP_OFS) begin
				next_rdata[`AFP_STEP_W-1:0] = steps_left;
			end else if (i_s_axi_araddr == `AFP_STEPS_DONE_OFS) begin
				next_rdata = steps_done;
			end else begin
				next_rresp = `AFP_RESP_SLVERR;
			end
		end
	end

	// Run sequence. The accelerator sees an edge in each cycle with o_acc_clk_en
	// high, so its outputs are only believed in those cycles.
	always_comb begin
		logic edge_seen;
		logic step_seen;
		edge_seen = o_acc_clk_en;
		step_seen = 1'b0;
		next_state = state;
		next_rst_cnt = rst_cnt;
		next_steps_left = steps_left;
		next_steps_done = steps_done;
		next_debug_mode = debug_mode;
		next_run_done = run_done;
		next_acc_clk_en = o_acc_clk_en;
		next_acc_reset = o_acc_reset;
		unique case (state)
			afp_pkg::afp_st_idle, afp_pkg::afp_st_stopped: begin
				if (start_req) begin
					next_state = afp_pkg::afp_st_reset;
					next_debug_mode = ctrl_val[`AFP_CTRL_DEBUG_BIT];
					next_rst_cnt = 3'h0;
					next_acc_clk_en = 1'b1;
					next_acc_reset = 1'b1;
					next_run_done = 1'b0;
					next_steps_done = 32'h0000_0000;
				end
			end
			afp_pkg::afp_st_reset: begin
				next_rst_cnt = rst_cnt + 3'h1;
				if (rst_cnt == `AFP_ACC_RESET_CYCLES - 3'h1) begin
					next_state = afp_pkg::afp_st_run;
					next_acc_reset = 1'b0;
					// Debug runs stop the clock after reset unless steps are already loaded
					next_acc_clk_en = ~debug_mode | (steps_left != '0);
				end
			end
			afp_pkg::afp_st_run: begin
				if (debug_mode) begin
					step_seen = edge_seen & i_step_flag;
				end
				if (step_seen) begin
					next_steps_done = steps_done + 32'h0000_0001;
					next_steps_left = steps_left - `AFP_STEP_W'(1);
				end
				if (step_req) begin
					next_steps_left = w_data[`AFP_STEP_W-1:0];
				end
				if (edge_seen && i_job_finished) begin
					next_state = afp_pkg::afp_st_last;
					next_acc_clk_en = 1'b1;
				end else if (debug_mode) begin
					// Stop after the edge that finished the last step
					next_acc_clk_en = next_steps_left != '0;
				end else begin
					next_acc_clk_en = 1'b1;
				end
			end
			afp_pkg::afp_st_last: begin
				next_state = afp_pkg::afp_st_stopped;
				next_acc_clk_en = 1'b0;
				next_run_done = 1'b1;
			end
			default: begin
				next_state = afp_pkg::afp_st_idle;
				next_acc_clk_en = 1'b0;
				next_acc_reset = 1'b0;
			end
		endcase
		if (step_req && state != afp_pkg::afp_st_run) begin
			next_steps_left = w_data[`AFP_STEP_W-1:0];
		end
		// Ports belong to the accelerator from reset until the run stops, debug pauses included
		next_grant = next_state == afp_pkg::afp_st_reset || next_state == afp_pkg::afp_st_run ||
			next_state == afp_pkg::afp_st_last;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= afp_pkg::afp_st_idle;
			rst_cnt <= 3'h0;
			steps_left <= '0;
			steps_done <= 32'h0000_0000;
			debug_mode <= 1'b0;
			run_done <= 1'b0;
			o_acc_clk_en <= 1'b0;
			o_acc_reset <= 1'b1;
			o_sram0_acc_grant <= 1'b0;
		end else begin
			state <= next_state;
			rst_cnt <= next_rst_cnt;
			steps_left <= next_steps_left;
			steps_done <= next_steps_done;
			debug_mode <= next_debug_mode;
			run_done <= next_run_done;
			o_acc_clk_en <= next_acc_clk_en;
			o_acc_reset <= next_acc_reset;
			o_sram0_acc_grant <= next_grant;
		end
	end

	// The reset values are constant straps from the accelerator, so loading
	// them straight from the ports under a synchronous reset is safe.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			if (i_param_reset_select) begin
				o_param_value <= i_param_reset_value;
			end
		end else begin
			o_param_value <= next_param;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
			w_held <= 1'b0;
			w_data <= `AFP_ZERO32;
			w_strb <= 4'h0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `AFP_RESP_OKAY;
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= `AFP_ZERO32;
			o_s_axi_rresp <= `AFP_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			o_s_axi_awready <= next_awready;
			o_s_axi_wready <= next_wready;
			o_s_axi_bvalid <= next_bvalid;
			o_s_axi_bresp <= next_bresp;
			o_s_axi_arready <= next_arready | (~o_s_axi_arready & ~o_s_axi_rvalid);
			o_s_axi_rvalid <= next_rvalid;
			o_s_axi_rdata <= next_rdata;
			o_s_axi_rresp <= next_rresp;
		end
	end

	// Requests only count while the accelerator owns the port and sees an edge
	afp_read_port #(
		.ADDR_W(`AFP_ADDR_W),
		.DATA_W(`AFP_DATA_W)
	) u_bank0_read (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_grant(o_sram0_acc_grant & o_acc_clk_en),
		.i_acc_addr(i_bank0_read_address),
		.i_acc_req(i_bank0_read_request),
		.o_mem_addr(o_sram0_rd_addr),
		.o_mem_req(o_sram0_rd_req),
		.i_mem_data(i_sram0_rd_data),
		.i_mem_valid(i_sram0_rd_valid),
		.o_acc_data(o_bank0_read_word),
		.o_acc_valid(o_bank0_read_valid)
	);
endmodule
`default_nettype wire

// >>> verilog/afp_defs.svh
// Constants for the accelerator framework port: register map, field positions,
// reset values and sequence counts. Included by bare name; definitions only.
`ifndef AFP_DEFS_SVH
`define AFP_DEFS_SVH

// Register byte offsets on the 12-bit AXI4-Lite address
`define AFP_CTRL_OFS 12'h000
`define AFP_STATUS_OFS 12'h004
`define AFP_STEP_OFS 12'h008
`define AFP_STEPS_DONE_OFS 12'h00C
// Param words: base + 8*n (low half), +4 (high half)
`define AFP_PARAM_BASE 4'h1
// Probe words: base + 8*n (low half), +4 (high half)
`define AFP_PROBE_BASE 3'h1

// Control register fields
`define AFP_CTRL_START_BIT 0
`define AFP_CTRL_DEBUG_BIT 1
// Status register fields
`define AFP_STAT_BUSY_BIT 0
`define AFP_STAT_DONE_BIT 1
`define AFP_STAT_RESET_BIT 2
`define AFP_STAT_DEBUG_BIT 3

// Widths and counts
`define AFP_PARAM_COUNT 8
`define AFP_PROBE_MAX 64
`define AFP_WORD_W 64
`define AFP_ADDR_W 20
`define AFP_DATA_W 128
`define AFP_STEP_W 16
// Accelerator clock cycles spent in reset before each run
`define AFP_ACC_RESET_CYCLES 3'h4

`define AFP_RESP_OKAY 2'h0
`define AFP_RESP_SLVERR 2'h2
`define AFP_ZERO32 32'h0000_0000

`endif

// >>> verilog/afp_pkg.sv
// Types shared by the accelerator framework port.
// Assumes nothing beyond a SystemVerilog compiler.
package afp_pkg;
	typedef enum logic [2:0] {
		afp_st_idle = 3'b000,
		afp_st_reset = 3'b001,
		afp_st_run = 3'b010,
		afp_st_last = 3'b011,
		afp_st_stopped = 3'b100
	} afp_run_state_e;
endpackage

// >>> verilog/afp_read_port.sv
// One SRAM read port as seen by the accelerator: forwards granted requests to
// the memory controller and registers the returned words toward the accelerator.
// Assumes the controller answers in request order on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "afp_defs.svh"

module afp_read_port #(
	parameter int ADDR_W = `AFP_ADDR_W,
	parameter int DATA_W = `AFP_DATA_W
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_grant,
	input wire logic [ADDR_W-1:0] i_acc_addr,
	input wire logic i_acc_req,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic o_mem_req,
	input wire logic [DATA_W-1:0] i_mem_data,
	input wire logic i_mem_valid,
	output logic [DATA_W-1:0] o_acc_data,
	output logic o_acc_valid
);
	logic [ADDR_W-1:0] next_mem_addr;
	logic next_mem_req;
	logic [DATA_W-1:0] next_acc_data;
	logic next_acc_valid;

	always_comb begin
		next_mem_req = i_grant & i_acc_req;
		next_mem_addr = i_acc_req ? i_acc_addr : o_mem_addr;
		// Controller keeps request order, so a plain stage keeps it too
		next_acc_valid = i_mem_valid;
		next_acc_data = i_mem_valid ? i_mem_data : o_acc_data;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_mem_req <= 1'b0;
			o_mem_addr <= '0;
			o_acc_valid <= 1'b0;
			o_acc_data <= '0;
		end else begin
			o_mem_req <= next_mem_req;
			o_mem_addr <= next_mem_addr;
			o_acc_valid <= next_acc_valid;
			o_acc_data <= next_acc_data;
		end
	end
endmodule
`default_nettype wire

// >>> verif/afp_top_assertions.sv
// Concurrent checks on the framework port top, bound to every afp_top.
// Assumes the reset phase of a run is clocked on every cycle.
`timescale 1ns/10ps
`default_nettype none
module afp_top_chk #(
	parameter int PROBE_COUNT = 64
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic o_acc_clk_en,
	input wire logic o_acc_reset,
	input wire logic i_job_finished,
	input wire logic [19:0] i_bank0_read_address,
	input wire logic i_bank0_read_request,
	input wire logic [127:0] o_bank0_read_word,
	input wire logic o_bank0_read_valid,
	input wire logic [19:0] o_sram0_rd_addr,
	input wire logic o_sram0_rd_req,
	input wire logic [127:0] i_sram0_rd_data,
	input wire logic i_sram0_rd_valid,
	input wire logic o_sram0_acc_grant
);
	logic [2:0] rst_cnt;
	logic [2:0] next_rst_cnt;
	always_comb begin
		next_rst_cnt = rst_cnt;
		if (!o_acc_reset) begin
			next_rst_cnt = 3'h0;
		end else if (o_acc_clk_en && rst_cnt != 3'h7) begin
			next_rst_cnt = rst_cnt + 3'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		rst_cnt <= i_sys_rst ? 3'h0 : next_rst_cnt;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	reset_len_a: assert property ($fell(o_acc_reset) |-> rst_cnt == 3'h4)
		else $error("accelerator reset not four clocked cycles");
	finish_tail_a: assert property (o_acc_clk_en && !o_acc_reset && $rose(i_job_finished) |=>
		o_acc_clk_en ##1 !o_acc_clk_en && !o_sram0_acc_grant)
		else $error("clock not stopped one cycle after finish");
	grant_held_a: assert property (o_acc_clk_en |-> o_sram0_acc_grant)
		else $error("clock running without grant");
	run_start_a: assert property ($rose(o_sram0_acc_grant) |-> o_acc_reset && o_acc_clk_en)
		else $error("run did not start in clocked reset");
	rd_issue_a: assert property (o_sram0_rd_req == $past(i_bank0_read_request && o_sram0_acc_grant && o_acc_clk_en))
		else $error("read request not forwarded once");
	rd_addr_a: assert property (i_bank0_read_request && o_sram0_acc_grant && o_acc_clk_en |=>
		o_sram0_rd_addr == $past(i_bank0_read_address))
		else $error("read address not forwarded");
	rd_valid_a: assert property (o_bank0_read_valid == $past(i_sram0_rd_valid))
		else $error("read valid does not follow memory");
	rd_word_a: assert property (i_sram0_rd_valid |=> o_bank0_read_word == $past(i_sram0_rd_data))
		else $error("read word does not follow memory");
endmodule
bind afp_top afp_top_chk #(.PROBE_COUNT(PROBE_COUNT)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.o_acc_clk_en(o_acc_clk_en), .o_acc_reset(o_acc_reset), .i_job_finished(i_job_finished),
	.i_bank0_read_address(i_bank0_read_address), .i_bank0_read_request(i_bank0_read_request),
	.o_bank0_read_word(o_bank0_read_word), .o_bank0_read_valid(o_bank0_read_valid),
	.o_sram0_rd_addr(o_sram0_rd_addr), .o_sram0_rd_req(o_sram0_rd_req), .i_sram0_rd_data(i_sram0_rd_data),
	.i_sram0_rd_valid(i_sram0_rd_valid), .o_sram0_acc_grant(o_sram0_acc_grant));
`default_nettype wire

// >>> verif/afp_acc_model.sv
// Accelerator stand-in: a three-read burst, in-order check, finish at a count.
// Assumes its clock is i_clk gated by i_acc_clk_en.
`timescale 1ns/10ps
`default_nettype none
module afp_acc_model #(
	parameter int FIN_AT = 12,
	parameter logic [31:0] REV = 32'h0000_0001,
	parameter logic [31:0] IDN = 32'h0000_0002,
	parameter logic CYCLE_STEP = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_acc_clk_en,
	input wire logic i_acc_reset,
	input wire logic [127:0] i_read_word,
	input wire logic i_read_valid,
	output logic [19:0] o_read_address,
	output logic o_read_request,
	output logic o_job_finished,
	output logic o_step_flag,
	output logic [4095:0] o_probe,
	output logic [511:0] o_param_rst,
	output logic o_param_sel,
	output logic [7:0] o_rx_count,
	output logic o_rx_bad
);
	logic [7:0] cnt, next_cnt, next_rx;
	logic next_req, next_fin, next_bad;
	logic [19:0] next_addr;
	always_comb begin
		next_cnt = cnt;
		next_rx = o_rx_count;
		next_req = o_read_request;
		next_fin = o_job_finished;
		next_bad = o_rx_bad;
		next_addr = o_read_address;
		if (i_acc_clk_en && i_acc_reset) begin
			next_cnt = 8'h00;
			next_rx = 8'h00;
			next_req = 1'b0;
			next_fin = 1'b0;
			next_bad = 1'b0;
		end else if (i_acc_clk_en) begin
			next_cnt = cnt + 8'h01;
			next_req = cnt < 8'h03;
			next_addr = 20'h0_0100 + 20'(cnt);
			next_fin = cnt == 8'(FIN_AT - 1);
			if (i_read_valid) begin
				next_rx = o_rx_count + 8'h01;
				next_bad = o_rx_bad | (i_read_word !== {4{12'h000, 20'h0_0100 + 20'(o_rx_count)}});
			end
		end
	end
	always_ff @(posedge i_clk) begin
		cnt <= i_sys_rst ? 8'h00 : next_cnt;
		o_rx_count <= i_sys_rst ? 8'h00 : next_rx;
		o_read_request <= i_sys_rst ? 1'b0 : next_req;
		o_job_finished <= i_sys_rst ? 1'b0 : next_fin;
		o_rx_bad <= i_sys_rst ? 1'b0 : next_bad;
		o_read_address <= i_sys_rst ? 20'h0_0000 : next_addr;
	end
	// One stepping style per build: cycle stepping ties the flag high, the
	// variable style marks every fourth accelerator cycle
	assign o_step_flag = CYCLE_STEP | (!i_acc_reset && cnt[1:0] == 2'h3);
	assign o_probe = {{63{64'hC3C3_3C3C_F00F_0FF0}}, IDN, REV};
	assign o_param_rst = {8{64'h1234_5678_9ABC_DEF0}};
	assign o_param_sel = 1'b1;
endmodule
`default_nettype wire

// >>> verif/tb_accelerator_framework_port.sv
// Self-checking bench: registers, probes, normal runs and stepping.
// Assumes a memory stand-in that answers three cycles after each request.
`timescale 1ns/10ps
`default_nettype none
`include "afp_defs.svh"
module tb_accelerator_framework_port;
	localparam int FIN = 12;
	localparam logic [31:0] REV = 32'h0000_0003; // Arbitrary value
	localparam logic [31:0] IDN = 32'h0000_0A5C; // Arbitrary value
	logic i_clk, i_sys_rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, en, ar, sf, jf, req, sreq, grant, rvd, sel, bad;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] br, rr;
	logic [19:0] addr, saddr;
	logic [127:0] word;
	logic [4095:0] probe;
	logic [511:0] pval, prst;
	logic [7:0] rxn;
	logic [2:0] vq;
	logic [19:0] aq [3];
	int mismatches, n_tests, cyc, rst_cyc, run_cyc, r0, q0;
	afp_top #(.PROBE_COUNT(4)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_s_axi_awaddr(awa),
		.i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rre), .o_acc_clk_en(en), .o_acc_reset(ar), .i_step_flag(sf), .i_job_finished(jf),
		.i_bank0_read_address(addr), .i_bank0_read_request(req), .o_bank0_read_word(word), .o_bank0_read_valid(rvd),
		.i_probe_output_n(probe), .o_param_value(pval), .i_param_reset_value(prst), .i_param_reset_select(sel),
		.o_sram0_rd_addr(saddr), .o_sram0_rd_req(sreq), .i_sram0_rd_data({4{12'h000, aq[2]}} ^ {128{!vq[2]}}),
		.i_sram0_rd_valid(vq[2]), .o_sram0_acc_grant(grant));
	afp_acc_model #(.FIN_AT(FIN), .REV(REV), .IDN(IDN)) i_acc (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_acc_clk_en(en), .i_acc_reset(ar), .i_read_word(word), .i_read_valid(rvd), .o_read_address(addr),
		.o_read_request(req), .o_job_finished(jf), .o_step_flag(sf), .o_probe(probe), .o_param_rst(prst),
		.o_param_sel(sel), .o_rx_count(rxn), .o_rx_bad(bad));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Memory stand-in: in order, idle data inverted so stale words never match
	always @(posedge i_clk) begin
		// Cleared under reset so no unknown valid reaches the port after release
		vq <= i_sys_rst ? 3'h0 : {vq[1:0], sreq};
		aq[0] <= saddr;
		aq[1] <= aq[0];
		aq[2] <= aq[1];
		rst_cyc <= rst_cyc + int'(en && ar);
		run_cyc <= run_cyc + int'(en && !ar);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [127:0] g, input logic [127:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge i_clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge i_clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		bre <= 1'b0;
		chk(128'(br), 128'(er));
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		int i;
		i = 0;
		do begin
			@(posedge i_clk);
			ara <= a;
			arv <= 1'b1;
			rre <= 1'b1;
			do begin
				@(posedge i_clk);
				if (arr) arv <= 1'b0;
			end while (!rv);
			rre <= 1'b0;
			i++;
		end while ((rd & m) !== e && i < 200);
		chk(128'(rd & m), 128'(e));
		chk(128'(rr), 128'(er));
	endtask
	function automatic logic [11:0] pa(input int n);
		return {`AFP_PARAM_BASE, 8'h00} + 12'(8 * n);
	endfunction
	function automatic logic [11:0] pr(input int n);
		return {`AFP_PROBE_BASE, 9'h000} + 12'(8 * n);
	endfunction
	task t_regs;
		rdc(pa(0), '1, 32'h9ABC_DEF0, `AFP_RESP_OKAY);
		rdc(pa(7) + 12'h004, '1, 32'h1234_5678, `AFP_RESP_OKAY);
		axw(pa(3), 32'hCAFE_0001, `AFP_RESP_OKAY);
		axw(pa(3) + 12'h004, 32'h0BAD_0002, `AFP_RESP_OKAY);
		chk(128'(pval[255:192]), 128'h0BAD_0002_CAFE_0001);
		axw(12'hFFC, 32'h0000_0001, `AFP_RESP_SLVERR);
		rdc(12'hFFC, '1, `AFP_ZERO32, `AFP_RESP_SLVERR);
		rdc(pr(0), '1, REV, `AFP_RESP_OKAY);
		rdc(pr(0) + 12'h004, '1, IDN, `AFP_RESP_OKAY);
		rdc(pr(3) + 12'h004, '1, 32'hC3C3_3C3C, `AFP_RESP_OKAY);
		rdc(pr(63), '1, `AFP_ZERO32, `AFP_RESP_OKAY);
	endtask
	task t_run;
		r0 = rst_cyc;
		q0 = run_cyc;
		axw(`AFP_CTRL_OFS, 32'h0000_0001, `AFP_RESP_OKAY);
		rdc(`AFP_STATUS_OFS, 32'h0000_0002, 32'h0000_0002, `AFP_RESP_OKAY);
		chk(128'(rst_cyc - r0), 128'(4));
		chk(128'(run_cyc - q0), 128'(FIN + 2));
		chk(128'({rxn, bad}), 128'({8'h03, 1'b0}));
		rdc(`AFP_STEPS_DONE_OFS, '1, `AFP_ZERO32, `AFP_RESP_OKAY);
		rdc(pa(3), '1, 32'hCAFE_0001, `AFP_RESP_OKAY);
	endtask
	task t_debug;
		r0 = rst_cyc;
		q0 = run_cyc;
		axw(`AFP_STEP_OFS, 32'h0000_0003, `AFP_RESP_OKAY);
		axw(`AFP_CTRL_OFS, 32'h0000_0003, `AFP_RESP_OKAY);
		rdc(`AFP_STEPS_DONE_OFS, 32'h0000_FFFF, 32'h0000_0003, `AFP_RESP_OKAY);
		chk(128'(rst_cyc - r0), 128'(4));
		chk(128'(run_cyc - q0), 128'(3));
		axw(`AFP_STEP_OFS, 32'h0000_0002, `AFP_RESP_OKAY);
		rdc(`AFP_STEPS_DONE_OFS, 32'h0000_FFFF, 32'h0000_0005, `AFP_RESP_OKAY);
		chk(128'(run_cyc - q0), 128'(5));
	endtask
	initial begin
		{i_sys_rst, awv, wv, bre, arv, rre, awa, ara, wd} = {6'b10_0000, 56'h0};
		{mismatches, n_tests, cyc, rst_cyc, run_cyc, vq} = '0;
		aq = '{default: 20'h0_0000};
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_regs();
		t_run();
		t_run();
		t_debug();
		end_of_test();
	end
endmodule
`default_nettype wire
